// *** core_pipe_model.sv ***
// Purpose: Issue stage of the core feeding register move requests
// Assumes: Bench presents one request per cycle on issue_in
// Notes:   Write data is not held once the request is gone
`timescale 1ns/10ps
module core_pipe_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // From bench
   input  wire logic        issue_in,
   input  wire logic [63:0] wdata_in,
   // To register bank
   output logic             req_valid_out,
   output logic [63:0]      req_wdata_out
);
   logic [63:0] last_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) last_q <= 64'h0;
      else if (issue_in) last_q <= wdata_in;
   end
   assign req_valid_out = issue_in;
   // Idle data shows the inverse, not a stale copy
   assign req_wdata_out = issue_in ? wdata_in : ~last_q;
endmodule : core_pipe_model

// *** mx_access_check.sv ***
// Purpose: Decides whether an access proceeds, traps or is undefined
// Assumes: Inputs are stable for the cycle of the request
// Notes:   Pure combinational
`timescale 1ns/10ps
module mx_access_check (
   mx_access_if.check acc
);
   wire mon_trap = acc.mon_present && acc.trap_lower_levels;
   wire mon_undef = acc.halted && acc.secure_debug_disable;
   mx_regs_pkg::result_t feat_res;
   mx_regs_pkg::result_t part_res;

   always_comb begin
      feat_res = mx_regs_pkg::RES_OK;
      if (!acc.is_64bit_state || acc.write) begin
         feat_res = mx_regs_pkg::RES_UNDEF;
      end else begin
         case (acc.level)
            mx_regs_pkg::EL_USER: begin
               if (!acc.id_trap_feature)
                  feat_res = mx_regs_pkg::RES_UNDEF;
               else if (acc.hyp_enabled && acc.general_trap_to_hyp)
                  feat_res = mx_regs_pkg::RES_TRAP2;
               else
                  feat_res = mx_regs_pkg::RES_TRAP1;
            end
            mx_regs_pkg::EL_KERN: begin
               if (acc.hyp_enabled && acc.id_group_trap)
                  feat_res = mx_regs_pkg::RES_TRAP2;
            end
            default: feat_res = mx_regs_pkg::RES_OK;
         endcase
      end
   end

   always_comb begin
      part_res = mx_regs_pkg::RES_OK;
      if (!acc.part_present || !acc.is_64bit_state) begin
         part_res = mx_regs_pkg::RES_UNDEF;
      end else begin
         case (acc.level)
            mx_regs_pkg::EL_USER: part_res = mx_regs_pkg::RES_UNDEF;
            mx_regs_pkg::EL_KERN: begin
               if (mon_trap)
                  part_res = mon_undef ? mx_regs_pkg::RES_UNDEF : mx_regs_pkg::RES_TRAP3;
               else if (acc.hyp_enabled && !acc.streaming_partition_reg_enable)
                  part_res = mx_regs_pkg::RES_TRAP2;
            end
            mx_regs_pkg::EL_HYP: begin
               if (mon_trap)
                  part_res = mon_undef ? mx_regs_pkg::RES_UNDEF : mx_regs_pkg::RES_TRAP3;
            end
            default: part_res = mx_regs_pkg::RES_OK;
         endcase
      end
   end

   assign acc.result = (acc.sel == mx_regs_pkg::SEL_FEAT) ? feat_res :
                       (acc.sel == mx_regs_pkg::SEL_PART) ? part_res :
                       mx_regs_pkg::RES_UNDEF;
endmodule : mx_access_check

// *** mx_access_if.sv ***
// Purpose: Carries one system-register access request and its outcome
// Assumes: Same clock as the register bank
// Notes:   Checker is combinational
`timescale 1ns/10ps
interface mx_access_if;
   mx_regs_pkg::level_t  level;
   mx_regs_pkg::sel_t    sel;
   logic                 write;
   logic                 is_64bit_state;
   logic                 hyp_enabled;
   logic                 mon_present;
   logic                 general_trap_to_hyp;
   logic                 id_group_trap;
   logic                 id_trap_feature;
   logic                 trap_lower_levels;
   logic                 streaming_partition_reg_enable;
   logic                 halted;
   logic                 secure_debug_disable;
   logic                 part_present;
   mx_regs_pkg::result_t result;

   modport bank (output level, sel, write, is_64bit_state, hyp_enabled, mon_present,
                 general_trap_to_hyp, id_group_trap, id_trap_feature, trap_lower_levels,
                 streaming_partition_reg_enable, halted, secure_debug_disable,
                 part_present, input result);
   modport check (input level, sel, write, is_64bit_state, hyp_enabled, mon_present,
                  general_trap_to_hyp, id_group_trap, id_trap_feature, trap_lower_levels,
                  streaming_partition_reg_enable, halted, secure_debug_disable,
                  part_present, output result);
endinterface : mx_access_if

// *** mx_regs.sv ***
// Purpose: Matrix feature id register and streaming partition label register
// Assumes: One request per cycle from the system-register move path
// Notes:   Answers one cycle after the request; labels one cycle after the memory request
//
// How it works
// - Feature id is 64-bit read only, kernel level up, 64-bit state only
// - Bit 63 shows full instruction set in streaming mode
// - Bits 59:56 give matrix version, always zero
// - Bits 55:52 are all zeros or all ones for int64 accumulate
// - Bit 48 shows double accumulate support
// - Bits 39:36 read all ones when matrix unit exists
// - Bits 35, 34, 32 read one when matrix unit exists
// - User read traps class 0x18 to hyp or kernel, or undefined
// - Kernel read traps to hyp on id group trap, else returns value
// - Partition register absent means access undefined
// - Matrix and streaming vector requests carry partition labels
// - Shared unit gives these labels precedence over per-level labels
// - Labels apply only while partitioning enable is one
// - User requests map partition virtually under user map conditions
// - Kernel requests map partition virtually under kernel map conditions
// - Monitor group at 47:40, partition id at 31:16, rest zero
// - Partition id unknown after warm reset
// - Writes take effect on the next request without invalidation
// - Kernel access traps to monitor on trap lower, undefined in debug
// - Otherwise kernel access traps to hyp if enable bit clear
// - Hyp level has same monitor check; monitor level always reaches
`timescale 1ns/10ps
module mx_regs #(
   parameter bit FULL_ISA    = 1'b0,
   parameter bit INT64_ACC   = 1'b1,
   parameter bit DOUBLE_ACC  = 1'b1,
   parameter bit MATRIX_IMPL = 1'b1,
   parameter bit PART_IMPL   = 1'b1,
   parameter bit SHARED_UNIT = 1'b1,
   parameter bit LOCAL_PREC  = 1'b1
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 rst_in,
   // Access request
   input  wire logic                 req_valid_in,
   input  wire logic                 req_write_in,
   input  wire logic [1:0]           req_sel_in,
   input  wire logic [1:0]           req_level_in,
   input  wire logic                 req_64bit_state_in,
   input  wire logic [63:0]          req_wdata_in,
   // Higher-level control bits
   input  wire logic                 hyp_enabled_in,
   input  wire logic                 mon_present_in,
   input  wire logic                 general_trap_to_hyp_in,
   input  wire logic                 host_mode_select_in,
   input  wire logic                 id_group_trap_in,
   input  wire logic                 id_trap_feature_in,
   input  wire logic                 trap_lower_levels_in,
   input  wire logic                 streaming_partition_reg_enable_in,
   input  wire logic                 halted_in,
   input  wire logic                 secure_debug_disable_in,
   input  wire logic                 partitioning_enable_in,
   input  wire logic                 virt_option_in,
   input  wire logic                 user_virtual_partition_map_enable_in,
   input  wire logic                 kernel_virtual_partition_map_enable_in,
   // Memory request labelling
   input  wire logic                 mem_req_in,
   input  wire logic                 mem_matrix_op_in,
   input  wire logic                 mem_vector_op_in,
   input  wire logic                 streaming_mode_in,
   input  wire logic [1:0]           mem_level_in,
   // Access answer
   output logic                      rsp_valid_out,
   output logic [2:0]                rsp_result_out,
   output logic [5:0]                rsp_class_out,
   output logic [63:0]               rsp_rdata_out,
   // Label answer
   output logic                      label_valid_out,
   output logic                      label_override_out,
   output logic                      label_virtual_out,
   output logic [15:0]               label_partition_id_out,
   output logic [7:0]                label_monitor_group_out
);

   mx_access_if acc ();

   logic [7:0]  monitor_group_data_q;
   logic [15:0] partition_id_data_q;
   logic        rsp_valid_q;
   logic [2:0]  rsp_result_q;
   logic [5:0]  rsp_class_q;
   logic [63:0] rsp_rdata_q;
   logic        label_valid_q;
   logic        label_override_q;
   logic        label_virtual_q;
   logic [15:0] label_partition_id_q;
   logic [7:0]  label_monitor_group_q;

   wire [63:0] feat_value;
   assign feat_value[mx_regs_pkg::FULL_ISA_BIT] = FULL_ISA;
   assign feat_value[62:60] = 3'h0;
   assign feat_value[mx_regs_pkg::VER_HI:mx_regs_pkg::VER_LO] = mx_regs_pkg::MATRIX_VER;
   assign feat_value[mx_regs_pkg::I64_HI:mx_regs_pkg::I64_LO] =
      INT64_ACC ? mx_regs_pkg::NIBBLE_ALL : 4'h0;
   assign feat_value[51:49] = 3'h0;
   assign feat_value[mx_regs_pkg::F64_BIT] = DOUBLE_ACC;
   assign feat_value[47:40] = 8'h00;
   assign feat_value[mx_regs_pkg::I8_HI:mx_regs_pkg::I8_LO] =
      MATRIX_IMPL ? mx_regs_pkg::NIBBLE_ALL : 4'h0;
   assign feat_value[mx_regs_pkg::HALF_BIT] = MATRIX_IMPL;
   assign feat_value[mx_regs_pkg::BF_BIT] = MATRIX_IMPL;
   assign feat_value[33] = 1'b0;
   assign feat_value[mx_regs_pkg::SINGLE_BIT] = MATRIX_IMPL;
   assign feat_value[31:0] = 32'h0000_0000;

   wire [63:0] part_value = {16'h0000, monitor_group_data_q, 8'h00,
                             partition_id_data_q, 16'h0000};

   assign acc.level = mx_regs_pkg::level_t'(req_level_in);
   assign acc.sel = req_valid_in ? mx_regs_pkg::sel_t'(req_sel_in) : mx_regs_pkg::SEL_NONE;
   assign acc.write = req_write_in;
   assign acc.is_64bit_state = req_64bit_state_in;
   assign acc.hyp_enabled = hyp_enabled_in;
   assign acc.mon_present = mon_present_in;
   assign acc.general_trap_to_hyp = general_trap_to_hyp_in;
   assign acc.id_group_trap = id_group_trap_in;
   assign acc.id_trap_feature = id_trap_feature_in;
   assign acc.trap_lower_levels = trap_lower_levels_in;
   assign acc.streaming_partition_reg_enable = streaming_partition_reg_enable_in;
   assign acc.halted = halted_in;
   assign acc.secure_debug_disable = secure_debug_disable_in;
   assign acc.part_present = PART_IMPL && MATRIX_IMPL;

   mx_access_check u_check (
      .acc (acc)
   );

   wire is_trap = (acc.result == mx_regs_pkg::RES_TRAP1) ||
                  (acc.result == mx_regs_pkg::RES_TRAP2) ||
                  (acc.result == mx_regs_pkg::RES_TRAP3);
   wire access_ok = req_valid_in && (acc.result == mx_regs_pkg::RES_OK);
   wire part_write = access_ok && req_write_in && (acc.sel == mx_regs_pkg::SEL_PART);
   wire [63:0] rdata_sel = !access_ok || req_write_in ? 64'h0 :
                           (acc.sel == mx_regs_pkg::SEL_FEAT) ? feat_value : part_value;

   always_ff @(posedge ref_clk_in) begin
      if (part_write) begin
         monitor_group_data_q <= req_wdata_in[mx_regs_pkg::PMG_HI:mx_regs_pkg::PMG_LO];
         partition_id_data_q <= req_wdata_in[mx_regs_pkg::PARTID_HI:mx_regs_pkg::PARTID_LO];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rsp_valid_q <= 1'b0;
         rsp_result_q <= 3'h0;
         rsp_class_q <= 6'h00;
         rsp_rdata_q <= 64'h0;
      end else begin
         rsp_valid_q <= req_valid_in;
         rsp_result_q <= acc.result;
         rsp_class_q <= (req_valid_in && is_trap) ? mx_regs_pkg::TRAP_CLASS : 6'h00;
         rsp_rdata_q <= rdata_sel;
      end
   end

   wire label_kind = mem_matrix_op_in || (streaming_mode_in && mem_vector_op_in);
   wire label_use = mem_req_in && label_kind && acc.part_present && partitioning_enable_in;
   wire label_prec = SHARED_UNIT ? 1'b1 : LOCAL_PREC;
   wire user_virt = (mem_level_in == mx_regs_pkg::EL_USER) && hyp_enabled_in &&
                    !(host_mode_select_in && general_trap_to_hyp_in) &&
                    virt_option_in && user_virtual_partition_map_enable_in;
   wire kern_virt = (mem_level_in == mx_regs_pkg::EL_KERN) && hyp_enabled_in &&
                    virt_option_in && kernel_virtual_partition_map_enable_in;

   // live register values, no cached copy
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         label_valid_q <= 1'b0;
         label_override_q <= 1'b0;
         label_virtual_q <= 1'b0;
         label_partition_id_q <= mx_regs_pkg::PARTID_RESET;
         label_monitor_group_q <= mx_regs_pkg::PMG_RESET;
      end else begin
         label_valid_q <= label_use;
         label_override_q <= label_use && label_prec;
         label_virtual_q <= label_use && (user_virt || kern_virt);
         label_partition_id_q <= label_use ? partition_id_data_q : 16'h0000;
         label_monitor_group_q <= label_use ? monitor_group_data_q : 8'h00;
      end
   end

   assign rsp_valid_out = rsp_valid_q;
   assign rsp_result_out = rsp_result_q;
   assign rsp_class_out = rsp_class_q;
   assign rsp_rdata_out = rsp_rdata_q;
   assign label_valid_out = label_valid_q;
   assign label_override_out = label_override_q;
   assign label_virtual_out = label_virtual_q;
   assign label_partition_id_out = label_partition_id_q;
   assign label_monitor_group_out = label_monitor_group_q;

   chk_user_feat_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h1 && req_level_in == 2'h0 && req_64bit_state_in
      && !req_write_in && id_trap_feature_in |=> rsp_class_out == 6'h18
      && rsp_rdata_out == 64'h0)
      else $error("user feature read not trapped");

   chk_kern_id_trap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h1 && req_level_in == 2'h1 && req_64bit_state_in
      && !req_write_in && hyp_enabled_in && id_group_trap_in
      |=> rsp_result_out == 3'h2)
      else $error("kernel id read not trapped to hyp");

   chk_feat_image: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h1 && req_level_in == 2'h3 && req_64bit_state_in
      && !req_write_in |=> rsp_rdata_out[39:32] == {4'hF, 4'hD} && rsp_rdata_out[31:0] == 0)
      else $error("feature image wrong");

   chk_mon_trap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h2 && req_level_in == 2'h1 && req_64bit_state_in
      && mon_present_in && trap_lower_levels_in && !halted_in
      |=> rsp_result_out == 3'h6 && rsp_class_out == 6'h18)
      else $error("monitor trap missed");

   chk_hyp_enable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h2 && req_level_in == 2'h1 && req_64bit_state_in
      && !(mon_present_in && trap_lower_levels_in) && hyp_enabled_in
      && !streaming_partition_reg_enable_in |=> rsp_result_out == 3'h2)
      else $error("hyp enable trap missed");

   chk_mon_direct: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h2 && req_level_in == 2'h2 && req_64bit_state_in
      |=> rsp_result_out == 3'h0)
      else $error("monitor level access blocked");

   chk_part_readback: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_write_in && req_sel_in == 2'h2 && req_level_in == 2'h2
      && req_64bit_state_in ##1 req_valid_in && !req_write_in && req_sel_in == 2'h2
      && req_level_in == 2'h2 && req_64bit_state_in
      |=> rsp_rdata_out == ($past(req_wdata_in, 2) & 64'h0000_FF00_FFFF_0000))
      else $error("partition readback wrong");

   chk_label_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !partitioning_enable_in |=> !label_valid_out && label_partition_id_out == 16'h0000)
      else $error("label used while partitioning off");

   chk_user_part: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_sel_in == 2'h2 && req_level_in == 2'h0 |=> rsp_result_out == 3'h1)
      else $error("user partition access not undefined");

   chk_feat_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_write_in && req_sel_in == 2'h1
      |=> rsp_result_out == 3'h1 && rsp_class_out == 6'h00 && rsp_rdata_out == 64'h0)
      else $error("feature id write not refused");

   chk_label_fresh: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      req_valid_in && req_write_in && req_sel_in == 2'h2 && req_level_in == 2'h2
      && req_64bit_state_in ##1 mem_req_in && mem_matrix_op_in && partitioning_enable_in
      |=> {16'h0000, label_monitor_group_out, 8'h00, label_partition_id_out, 16'h0000}
      == ($past(req_wdata_in, 2) & 64'h0000_FF00_FFFF_0000))
      else $error("labels lag the partition write");

   chk_label_prec: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      mem_req_in && mem_matrix_op_in && partitioning_enable_in
      |=> label_valid_out && label_override_out)
      else $error("labels lost precedence");

   chk_kern_virt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      mem_req_in && mem_matrix_op_in && partitioning_enable_in && mem_level_in == 2'h1
      && hyp_enabled_in && virt_option_in && kernel_virtual_partition_map_enable_in
      |=> label_virtual_out)
      else $error("kernel partition id not virtual");

   chk_user_virt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      mem_req_in && mem_matrix_op_in && partitioning_enable_in && mem_level_in == 2'h0
      && hyp_enabled_in && !(host_mode_select_in && general_trap_to_hyp_in)
      && virt_option_in && user_virtual_partition_map_enable_in |=> label_virtual_out)
      else $error("user partition id not virtual");

endmodule : mx_regs

// *** mx_regs_pkg.sv ***
// Purpose: Constants and types for the matrix feature id and streaming partition registers
// Assumes: Reached from the system-register move path of the core
// Notes:   Field positions, trap class and access outcomes live here
package mx_regs_pkg;

   // Exception levels
   typedef enum logic [1:0] {
      EL_USER  = 2'h0,
      EL_KERN  = 2'h1,
      EL_HYP   = 2'h3,
      EL_MON   = 2'h2
   } level_t;

   // Access outcome
   typedef enum logic [2:0] {
      RES_OK     = 3'h0,
      RES_UNDEF  = 3'h1,
      RES_TRAP1  = 3'h3,
      RES_TRAP2  = 3'h2,
      RES_TRAP3  = 3'h6
   } result_t;

   // Register selector
   typedef enum logic [1:0] {
      SEL_NONE  = 2'h0,
      SEL_FEAT  = 2'h1,
      SEL_PART  = 2'h2
   } sel_t;

   localparam logic [5:0] TRAP_CLASS = 6'h18;

   // Feature id field positions
   localparam int FULL_ISA_BIT   = 63;
   localparam int VER_HI         = 59;
   localparam int VER_LO         = 56;
   localparam int I64_HI         = 55;
   localparam int I64_LO         = 52;
   localparam int F64_BIT        = 48;
   localparam int I8_HI          = 39;
   localparam int I8_LO          = 36;
   localparam int HALF_BIT       = 35;
   localparam int BF_BIT         = 34;
   localparam int SINGLE_BIT     = 32;
   localparam logic [3:0] MATRIX_VER = 4'h0;
   localparam logic [3:0] NIBBLE_ALL = 4'hF;

   // Partition register field positions
   localparam int PMG_HI         = 47;
   localparam int PMG_LO         = 40;
   localparam int PARTID_HI      = 31;
   localparam int PARTID_LO      = 16;
   localparam logic [7:0]  PMG_RESET    = 8'h00;
   localparam logic [15:0] PARTID_RESET = 16'h0000;

endpackage : mx_regs_pkg

// *** tb_top.sv ***
// Purpose: Random and corner checks of the matrix id and partition registers
// Assumes: Default parameters of the register bank
// Notes:   Answers are checked at the falling edge after they land
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, rst = 1'b1, issue = 1'b0, wr = 1'b0, st64 = 1'b0, rv;
   logic [1:0] sel = 2'h0, lvl = 2'h0;
   logic [13:0] c = 14'h0;
   logic [5:0] m = 6'h0;
   logic [63:0] wd = 64'h0, rwd, part_m, e_rd = 64'h0;
   logic [31:0] seed = 32'h53A6, hi_w = 32'h0;
   logic e_v = 1'b0, l_v = 1'b0, l_ov, l_vi, rsp_v, lab_v, lab_ov, lab_vi;
   logic [2:0] e_res, rsp_res;
   logic [5:0] e_cls, rsp_cls;
   logic [63:0] rsp_rd;
   logic [15:0] l_id, lab_id;
   logic [7:0] l_mg, lab_mg;
   int n_errors = 0, check_count = 0, cyc = 0;
   logic [31:0] corner [8] = '{32'h06B00000, 32'h0690C400, 32'h07700000, 32'h07500000,
                               32'h05500011, 32'h04500025, 32'h05900342, 32'h01500000};
   always #12.5 clk = ~clk;
   core_pipe_model core_pipe_model_inst (.clk_in(clk), .rst_in(rst), .issue_in(issue),
      .wdata_in(wd), .req_valid_out(rv), .req_wdata_out(rwd));
   mx_regs mx_regs_inst (.ref_clk_in(clk), .rst_in(rst), .req_valid_in(rv),
      .req_write_in(wr), .req_sel_in(sel), .req_level_in(lvl), .req_64bit_state_in(st64),
      .req_wdata_in(rwd), .hyp_enabled_in(c[0]), .mon_present_in(c[1]),
      .general_trap_to_hyp_in(c[2]), .host_mode_select_in(c[3]), .id_group_trap_in(c[4]),
      .id_trap_feature_in(c[5]), .trap_lower_levels_in(c[6]),
      .streaming_partition_reg_enable_in(c[7]), .halted_in(c[8]),
      .secure_debug_disable_in(c[9]), .partitioning_enable_in(c[10]),
      .virt_option_in(c[11]), .user_virtual_partition_map_enable_in(c[12]),
      .kernel_virtual_partition_map_enable_in(c[13]), .mem_req_in(m[0]),
      .mem_matrix_op_in(m[1]), .mem_vector_op_in(m[2]), .streaming_mode_in(m[3]),
      .mem_level_in(m[5:4]), .rsp_valid_out(rsp_v), .rsp_result_out(rsp_res),
      .rsp_class_out(rsp_cls), .rsp_rdata_out(rsp_rd), .label_valid_out(lab_v),
      .label_override_out(lab_ov), .label_virtual_out(lab_vi),
      .label_partition_id_out(lab_id), .label_monitor_group_out(lab_mg));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [2:0] acc_res(input logic w, input logic [1:0] s,
                                          input logic [1:0] l, input logic st,
                                          input logic [13:0] k);
      if (!st || s == 2'h0 || s == 2'h3) return mx_regs_pkg::RES_UNDEF;
      if (s == 2'h1) begin
         if (w) return mx_regs_pkg::RES_UNDEF;
         if (l == mx_regs_pkg::EL_USER) begin
            if (!k[5]) return mx_regs_pkg::RES_UNDEF;
            return (k[0] & k[2]) ? mx_regs_pkg::RES_TRAP2 : mx_regs_pkg::RES_TRAP1;
         end
         if (l == mx_regs_pkg::EL_KERN && k[0] && k[4]) return mx_regs_pkg::RES_TRAP2;
         return mx_regs_pkg::RES_OK;
      end
      if (l == mx_regs_pkg::EL_USER) return mx_regs_pkg::RES_UNDEF;
      if (l != mx_regs_pkg::EL_MON && k[1] && k[6])
         return (k[8] & k[9]) ? mx_regs_pkg::RES_UNDEF : mx_regs_pkg::RES_TRAP3;
      if (l == mx_regs_pkg::EL_KERN && k[0] && !k[7]) return mx_regs_pkg::RES_TRAP2;
      return mx_regs_pkg::RES_OK;
   endfunction : acc_res
   task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (e !== g) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic step(input logic [31:0] x, input logic [63:0] d);
      @(posedge clk);
      issue <= x[20]; wr <= x[21]; sel <= x[23:22]; lvl <= x[25:24];
      st64 <= |x[27:26]; wd <= d; c <= x[13:0]; m <= x[19:14];
      @(negedge clk);
      cmp("rsp_valid", 64'(e_v), 64'(rsp_v));
      if (e_v) begin
         cmp("result", 64'(e_res), 64'(rsp_res));
         cmp("class", 64'(e_cls), 64'(rsp_cls));
         cmp("rdata", e_rd, rsp_rd);
      end
      cmp("label_valid", 64'(l_v), 64'(lab_v));
      if (l_v) begin
         cmp("override", 64'(l_ov), 64'(lab_ov));
         cmp("virtual", 64'(l_vi), 64'(lab_vi));
         cmp("partition_id", 64'(l_id), 64'(lab_id));
         cmp("monitor_group", 64'(l_mg), 64'(lab_mg));
      end
      l_v = x[14] & (x[15] | (x[17] & x[16])) & x[10];
      l_ov = 1'b1;
      l_vi = (x[19:18] == 2'h0) ? x[0] & !(x[3] & x[2]) & x[11] & x[12] :
             (x[19:18] == 2'h1) ? x[0] & x[11] & x[13] : 1'b0;
      l_id = part_m[31:16];
      l_mg = part_m[47:40];
      e_v = x[20];
      e_res = acc_res(x[21], x[23:22], x[25:24], |x[27:26], x[13:0]);
      e_cls = (e_res inside {mx_regs_pkg::RES_OK, mx_regs_pkg::RES_UNDEF}) ?
              6'h00 : mx_regs_pkg::TRAP_CLASS;
      e_rd = 64'h0;
      if (!x[21] && e_res == mx_regs_pkg::RES_OK)
         e_rd = (x[23:22] == 2'h1) ? 64'h00F1_00FD_0000_0000 : part_m;
      if (x[20] && x[21] && e_res == mx_regs_pkg::RES_OK && x[23:22] == 2'h2)
         part_m = d & 64'h0000_FF00_FFFF_0000;
   endtask : step
   task automatic complete_run;
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (corner[i]) step(corner[i], 64'hFFFF_FFFF_FFFF_FFFF);
      repeat (3000) begin
         seed = lfsr(seed);
         hi_w = seed;
         seed = lfsr(seed);
         step(seed, {hi_w, seed ^ 32'h5A5A_C3C3});
      end
      step(32'h0, 64'h0);
      complete_run();
   end
endmodule : tb_top
